// ### rtl/flut_defs.svh
/*
  Constants for the fan lookup table slice (entries 8 and 9):
  register offsets, field positions and reset values.
  Assumes an 8-bit register address space and 8-bit register data.
*/
`ifndef FLUT_DEFS_SVH
`define FLUT_DEFS_SVH

// --------------------------------------------------------------------
// register offsets
// --------------------------------------------------------------------
`define FLUT_ADDR_THRESH8 8'h5e
`define FLUT_ADDR_DUTY8 8'h5f
`define FLUT_ADDR_THRESH9 8'h60
`define FLUT_ADDR_DUTY9 8'h61

// --------------------------------------------------------------------
// reset values
// --------------------------------------------------------------------
`define FLUT_THRESH_RESET 8'h7f
`define FLUT_DUTY_RESET 8'h3f
`define FLUT_RDATA_UNMAPPED 8'h00

// --------------------------------------------------------------------
// field positions
// --------------------------------------------------------------------
`define FLUT_THRESH_HALF_BIT 7
`define FLUT_THRESH_LOW_MSB 6
`define FLUT_DUTY_EXT_MSB 7
`define FLUT_DUTY_EXT_LSB 6
`define FLUT_DUTY_BASE_MSB 5

`endif

// ### rtl/flut_pkg.sv
/*
  Types for the fan lookup table slice: register bus request and
  the packed state of the block.
  Assumes flut_defs.svh is not needed here; types only.
*/
`default_nettype none

package flut_pkg;

  // ------------------------------------------------------------------
  // register bus request
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } flut_bus_req_t;

  // ------------------------------------------------------------------
  // mode selects from the rest of the device
  // ------------------------------------------------------------------
  typedef struct packed {
    logic temp_hi_res;
    logic duty_hi_res;
    logic pwm_freq_22k5;
  } flut_mode_t;

  // ------------------------------------------------------------------
  // whole block state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] thresh8;
    logic [7:0] duty8;
    logic [7:0] thresh9;
    logic [7:0] duty9;
    logic [7:0] rd_data;
    logic [7:0] duty;
    logic duty_active;
  } flut_state_t;

endpackage : flut_pkg

`default_nettype wire

// ### rtl/flut_entries.sv
/*
  Fan lookup table entries 8 and 9: two threshold/duty register pairs,
  their register port, and the selection of the fan duty value from the
  remote temperature.
  Assumes the table write enable, resolution selects, pwm frequency
  select, table temperature offset and temperature reading all come from
  logic on i_clk_sys; the pwm generator sits outside.
*/
// Local design decision: the address-and-strobe port.
`include "flut_defs.svh"
`default_nettype none

// Summary of operation
// - threshold writes take effect only while table write enable is set; reads always
// - low-resolution temperature mode: threshold bit 7 reads as zero
// - high-resolution temperature mode: bit 7 is the half-degree bit of the threshold
// - high-resolution threshold spans 0 to 127.5 degrees in half-degree steps
// - low-resolution threshold spans 0 to 127 degrees in whole-degree steps
// - temperature above a threshold selects its paired duty register as pwm value; entry 9 wins when both are exceeded
// - compare 9 temperature bits in high resolution, 8 bits in low resolution
// - threshold sign bit is always treated as zero
// - table temperature offset is added to each threshold before comparing
// - low-resolution duty mode: duty bits 7:6 read as zero
// - high-resolution duty mode: bits 7:6 extend bits 5:0 of the duty value
// - duty extension bits act only with 22.5 kHz pwm selected
// - low-resolution pwm mode: duty bits 5:0 alone give the pwm value
module flut_entries
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // register port
  input wire flut_pkg::flut_bus_req_t i_bus,
  output logic [7:0] o_rd_data,
  // device configuration
  input wire logic i_table_wr_enable,
  input wire flut_pkg::flut_mode_t i_mode,
  input wire logic [7:0] i_temp_offset,
  // remote temperature reading
  input wire logic [7:0] i_remote_temp_int,
  input wire logic i_remote_temp_half,
  input wire logic i_remote_temp_valid,
  // fan duty output
  output logic [7:0] o_duty,
  output logic o_duty_active
);
  import flut_pkg::*;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // threshold in half degrees, offset added, sign forced zero
  function automatic logic [9:0] thresh_eff(input logic [7:0] thr, input logic hi,
                                            input logic [7:0] ofs);
    logic [9:0] base;
    base = 10'h000;
    if (hi)
    begin
      base = {2'b00, thr[`FLUT_THRESH_LOW_MSB:0], thr[`FLUT_THRESH_HALF_BIT]};
    end
    else
    begin
      base = {2'b00, thr[`FLUT_THRESH_LOW_MSB:0], 1'b0};
    end
    thresh_eff = base + {1'b0, ofs, 1'b0};
  endfunction : thresh_eff

  // temperature in half degrees
  function automatic logic [9:0] temp_eff(input logic [7:0] t, input logic half,
                                          input logic hi);
    temp_eff = {1'b0, t, hi & half};
  endfunction : temp_eff

  // duty value applied to the fan
  function automatic logic [7:0] duty_eff(input logic [7:0] d, input flut_mode_t m);
    if (m.duty_hi_res && m.pwm_freq_22k5)
    begin
      duty_eff = d;
    end
    else
    begin
      duty_eff = {2'b00, d[`FLUT_DUTY_BASE_MSB:0]};
    end
  endfunction : duty_eff

  // read view of a threshold
  function automatic logic [7:0] thresh_view(input logic [7:0] thr, input logic hi);
    thresh_view = {hi & thr[`FLUT_THRESH_HALF_BIT], thr[`FLUT_THRESH_LOW_MSB:0]};
  endfunction : thresh_view

  // read view of a duty entry
  function automatic logic [7:0] duty_view(input logic [7:0] d, input logic hi);
    duty_view = {d[`FLUT_DUTY_EXT_MSB:`FLUT_DUTY_EXT_LSB] & {2{hi}},
                 d[`FLUT_DUTY_BASE_MSB:0]};
  endfunction : duty_view

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  flut_state_t state_q;
  flut_state_t state_d;
  logic [9:0] temp_cmp;
  logic over8;
  logic over9;

  always_comb
  begin
    state_d = state_q;
    temp_cmp = temp_eff(i_remote_temp_int, i_remote_temp_half, i_mode.temp_hi_res);
    over8 = temp_cmp > thresh_eff(state_q.thresh8, i_mode.temp_hi_res, i_temp_offset);
    over9 = temp_cmp > thresh_eff(state_q.thresh9, i_mode.temp_hi_res, i_temp_offset);

    // register writes
    if (i_bus.wr && i_table_wr_enable)
    begin
      if (i_bus.addr == `FLUT_ADDR_THRESH8)
      begin
        state_d.thresh8 = i_bus.wdata;
      end
      else if (i_bus.addr == `FLUT_ADDR_DUTY8)
      begin
        state_d.duty8 = i_bus.wdata;
      end
      else if (i_bus.addr == `FLUT_ADDR_THRESH9)
      begin
        state_d.thresh9 = i_bus.wdata;
      end
      else if (i_bus.addr == `FLUT_ADDR_DUTY9)
      begin
        state_d.duty9 = i_bus.wdata;
      end
    end

    // register reads, data in the following cycle only
    state_d.rd_data = `FLUT_RDATA_UNMAPPED;
    if (i_bus.rd)
    begin
      if (i_bus.addr == `FLUT_ADDR_THRESH8)
      begin
        state_d.rd_data = thresh_view(state_q.thresh8, i_mode.temp_hi_res);
      end
      else if (i_bus.addr == `FLUT_ADDR_DUTY8)
      begin
        state_d.rd_data = duty_view(state_q.duty8, i_mode.duty_hi_res);
      end
      else if (i_bus.addr == `FLUT_ADDR_THRESH9)
      begin
        state_d.rd_data = thresh_view(state_q.thresh9, i_mode.temp_hi_res);
      end
      else if (i_bus.addr == `FLUT_ADDR_DUTY9)
      begin
        state_d.rd_data = duty_view(state_q.duty9, i_mode.duty_hi_res);
      end
    end

    // table evaluation on each new reading
    if (i_remote_temp_valid)
    begin
      if (over9)
      begin
        state_d.duty = duty_eff(state_q.duty9, i_mode);
        state_d.duty_active = 1'b1;
      end
      else if (over8)
      begin
        state_d.duty = duty_eff(state_q.duty8, i_mode);
        state_d.duty_active = 1'b1;
      end
      else
      begin
        state_d.duty = 8'h00;
        state_d.duty_active = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state_q.thresh8 <= `FLUT_THRESH_RESET;
      state_q.duty8 <= `FLUT_DUTY_RESET;
      state_q.thresh9 <= `FLUT_THRESH_RESET;
      state_q.duty9 <= `FLUT_DUTY_RESET;
      state_q.rd_data <= `FLUT_RDATA_UNMAPPED;
      state_q.duty <= 8'h00;
      state_q.duty_active <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign o_rd_data = state_q.rd_data;
  assign o_duty = state_q.duty;
  assign o_duty_active = state_q.duty_active;

endmodule : flut_entries

`default_nettype wire

// ### bench/flut_entries_chk.sv
/* port checker for flut_entries; bound to every instance below.
   assumes the single clock i_clk_sys and async reset i_reset_n */
`include "flut_defs.svh"
`default_nettype none
module flut_entries_chk
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // register port
  input wire flut_pkg::flut_bus_req_t i_bus,
  input wire logic [7:0] o_rd_data,
  // configuration and reading
  input wire logic i_table_wr_enable,
  input wire flut_pkg::flut_mode_t i_mode,
  input wire logic [7:0] i_temp_offset,
  input wire logic [7:0] i_remote_temp_int,
  input wire logic i_remote_temp_half,
  input wire logic i_remote_temp_valid,
  // fan duty
  input wire logic [7:0] o_duty,
  input wire logic o_duty_active
);
  timeunit 1ns;
  timeprecision 100ps;
  import flut_pkg::*;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  logic thr_a;
  logic dut_a;
  assign thr_a = i_bus.addr == `FLUT_ADDR_THRESH8 || i_bus.addr == `FLUT_ADDR_THRESH9;
  assign dut_a = i_bus.addr == `FLUT_ADDR_DUTY8 || i_bus.addr == `FLUT_ADDR_DUTY9;
  AST_RD_IDLE: assert property (!i_bus.rd |=> o_rd_data == 8'h00)
    else $error("read data outside read slot");
  AST_THR_LO: assert property (i_bus.rd && thr_a && !i_mode.temp_hi_res |=> !o_rd_data[7])
    else $error("threshold bit 7 set in low res");
  AST_DUTY_LO: assert property (i_bus.rd && dut_a && !i_mode.duty_hi_res
    |=> o_rd_data[7:6] == 2'b00) else $error("duty bits 7:6 set in low res");
  AST_EXT_OFF: assert property (i_remote_temp_valid
    && !(i_mode.duty_hi_res && i_mode.pwm_freq_22k5) |=> o_duty[7:6] == 2'b00)
    else $error("extended duty used");
  AST_IDLE_ZERO: assert property (!o_duty_active |-> o_duty == 8'h00)
    else $error("duty without exceeded entry");
  AST_DUTY_HOLD: assert property (!i_remote_temp_valid |=> $stable(o_duty))
    else $error("duty changed without reading");
  AST_ACT_HOLD: assert property (!i_remote_temp_valid |=> $stable(o_duty_active))
    else $error("active changed without reading");
  AST_COLD: assert property (i_remote_temp_valid && i_remote_temp_int == 8'h00
    && !i_remote_temp_half |=> !o_duty_active) else $error("zero degrees exceeded");
  cover property (i_remote_temp_valid ##1 o_duty_active);
  cover property (i_bus.rd && thr_a);
  cover property (i_bus.wr && i_table_wr_enable);
endmodule : flut_entries_chk
bind flut_entries flut_entries_chk chk (.*);
`default_nettype wire

// ### bench/flut_fan_model.sv
/* fan model: speed follows the applied duty.
   assumes duty and run flag from flut_entries */
`default_nettype none
module flut_fan_model
(
  // clock and drive
  input wire logic i_clk_sys,
  input wire logic [7:0] i_duty,
  input wire logic i_run,
  // fan state
  output logic [7:0] o_speed
);
  timeunit 1ns;
  timeprecision 100ps;
  always_ff @(posedge i_clk_sys)
  begin
    o_speed <= i_run ? i_duty : 8'h00;
  end
endmodule : flut_fan_model
`default_nettype wire

// ### bench/flut_entries_tb_top.sv
/* self-checking bench for flut_entries with fan model.
   assumes the checker is bound through its own file */
`default_nettype none
module flut_entries_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import flut_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, wen = 1'b0, half = 1'b0, valid = 1'b0, act;
  flut_bus_req_t bus = '0;
  flut_mode_t mode = '0;
  logic [7:0] ofs = 8'h00, tint = 8'h00, rd_data, duty, speed;
  int n_mismatch = 0, n_compared = 0;
  initial forever #25 clk = ~clk;
  flut_entries dut (.i_clk_sys(clk), .i_reset_n(rst_n), .i_bus(bus), .o_rd_data(rd_data),
    .i_table_wr_enable(wen), .i_mode(mode), .i_temp_offset(ofs), .i_remote_temp_int(tint),
    .i_remote_temp_half(half), .i_remote_temp_valid(valid), .o_duty(duty), .o_duty_active(act));
  flut_fan_model fan (.i_clk_sys(clk), .i_duty(duty), .i_run(act), .o_speed(speed));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) bus <= '0;
  endtask : wr
  task rc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) bus <= '0;
    #1 chk(rd_data, e);
  endtask : rc
  task ev(input logic [7:0] t, input logic h, input logic [7:0] e, input logic ea);
    @(posedge clk);
    tint <= t;
    half <= h;
    valid <= 1'b1;
    @(posedge clk) valid <= 1'b0;
    #1 chk(duty, e);
    chk({7'h00, act}, {7'h00, ea});
  endtask : ev
  task t_regs;
    mode <= '1;
    rc(8'h5e, 8'h7f);
    rc(8'h5f, 8'h3f);
    rc(8'h60, 8'h7f);
    rc(8'h61, 8'h3f);
    wr(8'h5e, 8'h00);
    rc(8'h5e, 8'h7f);
    wen <= 1'b1;
    wr(8'h5e, 8'h28);
    wr(8'h5f, 8'hc5);
    wr(8'h60, 8'h32);
    wr(8'h61, 8'h2a);
    rc(8'h5f, 8'hc5);
    rc(8'h10, 8'h00);
  endtask : t_regs
  task t_low;
    mode <= '0;
    rc(8'h5f, 8'h05);
    ev(8'h2d, 1'b0, 8'h05, 1'b1);
    ev(8'h33, 1'b0, 8'h2a, 1'b1);
    ev(8'h28, 1'b1, 8'h00, 1'b0);
    ev(8'h00, 1'b0, 8'h00, 1'b0);
    ofs <= 8'h0a;
    ev(8'h2d, 1'b0, 8'h00, 1'b0);
    ofs <= 8'h00;
  endtask : t_low
  task t_high;
    wr(8'h5e, 8'ha8);
    rc(8'h5e, 8'h28);
    mode <= '{1'b1, 1'b0, 1'b1};
    rc(8'h5e, 8'ha8);
    ev(8'h28, 1'b1, 8'h00, 1'b0);
    ev(8'h29, 1'b0, 8'h05, 1'b1);
    mode <= '1;
    ev(8'h29, 1'b0, 8'hc5, 1'b1);
    mode <= '{1'b1, 1'b1, 1'b0};
    ev(8'h29, 1'b0, 8'h05, 1'b1);
    #50 chk(speed, 8'h05);
  endtask : t_high
  task wrap_up;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_low;
    t_high;
    wrap_up;
  end
endmodule : flut_entries_tb_top
`default_nettype wire
